// File: flash_status_config_regs.sv
`timescale 1ns/1ps
// Operation
// R1 - Guard bit set lets the write-guard pin lock the registers
// R2 - Granularity bit picks 64-KB blocks when 0, 4-KB sectors when 1
// R3 - Range field in first register bits 4..2; zero means unprotected
// R4 - Range field comes up zero, leaving the array unprotected
// R5 - Latch set by write enable; cleared by reset, disable, ops
// R6 - No program, erase or status write starts without the latch
// R7 - Busy reads 1 during operations; only status reads are served (code also acts on suspend during program/erase)
// R8 - Busy clears when the operation finishes
// R9 - Top/bottom bit picks range origin; defaults to top
// R10 - Top/bottom changes only as guard and latch permit
// R11 - Invert bit complements the chosen protected region
// R12 - Paused flag reads 1 while an operation is suspended
// R13 - Three one-time lock bits, one per security page, start at 0
// R14 - Quad enable turns guard and hold/reset pins into data lines
// R15 - Pin select chooses hold or reset, only without quad enable
// R16 - Two-bit drive strength field applied to read drivers
// R17 - High-frequency mode bit, default off
// R18 - Reset reloads volatile copies from non-volatile copies
// R19 - Volatile enable then write updates only volatile copies
// R20 - Guard set and pin low rejects first and second writes
// R21 - Reserved bits read zero and ignore writes
module flash_status_config_regs
  import flash_status_pkg::*;
#(
  parameter int         TW_CYCLES      = STATUS_WRITE_CYCLES,
  parameter int         RST_CYCLES     = SOFT_RESET_CYCLES,
  parameter logic [7:0] CMD_READ_SR1   = 8'h05,
  parameter logic [7:0] CMD_READ_SR2   = 8'h35,
  parameter logic [7:0] CMD_READ_SR3   = 8'h15,
  parameter logic [7:0] CMD_WRITE_SR3  = 8'h11,
  parameter logic [7:0] CMD_WRITE_DIS  = 8'h04
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       io0_di_i,
  input  wire logic       io2_wp_n_i,
  input  wire logic       io3_hold_reset_n_i,
  input  wire logic       array_op_req_i,
  input  wire logic       array_op_done_i,
  output logic            io1_do_o,
  output logic            io1_do_oe_n_o,
  output logic            array_grant_o,
  output logic            device_reset_o,
  output protection_type  protection_o,
  output logic      [2:0] security_lock_o,
  output logic            quad_io_enable_o,
  output logic            hold_active_o,
  output logic      [1:0] drive_strength_o,
  output logic            high_freq_mode_o,
  output logic            write_latch_o,
  output logic            busy_o,
  output logic            paused_o
);

  typedef struct packed {
    cfg_type            vol;
    cfg_type            nv;
    logic [2:0]         lock;
    logic               write_latch_flag;
    logic               vwe;
    op_kind_type        kind;
    logic               paused;
    logic               armed;
    logic [7:0]         cmd;
    logic               cmd_valid;
    logic [1:0]         nbytes;
    logic [15:0]        wdata;
    logic [1:0]         pend_sel;
    logic               pend_two;
    logic [15:0]        pend_data;
    logic [TIMER_W-1:0] timer;
  } ctl_state_type;

  localparam int TW_BOUND = TW_CYCLES + 1;

  ctl_state_type st;
  ctl_state_type next_st;
  logic [4:0]    pins_s;
  logic          sclk_s;
  logic          cs_n_s;
  logic          di_s;
  logic          wp_n_s;
  logic          hold_n_s;
  logic [7:0]    rx_byte;
  logic          rx_valid;
  logic          frame_end;
  logic          aligned;
  logic [7:0]    tx_byte;
  logic          busy;
  logic          pin_fn_on;
  logic          hold_on;
  logic          pin_reset;
  logic          guard_on;
  logic          wp_lock;
  logic          exec;
  logic          reading;
  logic          grant;
  logic          soft_reset;
  logic          wr_cmd;
  logic          wr_two;
  logic          wr_blocked;
  logic [1:0]    wr_sel;

  // One or two data bytes; the second of a first-register write
  // lands in the second register
  function automatic cfg_type apply_write(cfg_type c, logic [1:0] sel,
                                          logic two, logic [15:0] d);
    cfg_type r;
    r = cfg_merge(c, sel, d[15:8]);
    if (two) begin
      r = cfg_merge(r, SEL_SR2, d[7:0]);
    end
    return r;
  endfunction

  // One-time bits can only be set, never cleared
  function automatic logic [2:0] lock_merge(logic [2:0] lock,
                                            logic [1:0] sel, logic two,
                                            logic [15:0] d);
    logic [7:0] b;
    b = 8'h00;
    if (sel == SEL_SR2) begin
      b = d[15:8];
    end else if (two) begin
      b = d[7:0];
    end
    return lock | b[SR2_LOCK_HI:SR2_LOCK_LO];
  endfunction

  // All pins come from outside the clock domain
  sync2 #(
    .WIDTH       (5),
    .RESET_VALUE (5'h1F)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({sclk_i, cs_n_i, io0_di_i, io2_wp_n_i,
                 io3_hold_reset_n_i}),
    .sync_o    (pins_s)
  );

  assign {sclk_s, cs_n_s, di_s, wp_n_s, hold_n_s} = pins_s;

  // Shared pin functions exist only without quad mode
  assign pin_fn_on = ~st.vol.quad; // R14
  assign hold_on   = pin_fn_on & ~st.vol.pin_sel & ~hold_n_s & ~cs_n_s; // R15
  assign pin_reset = pin_fn_on & st.vol.pin_sel & ~hold_n_s; // R15
  assign guard_on  = st.vol.guard; // R1
  assign wp_lock   = guard_on & pin_fn_on & ~wp_n_s; // R20

  // A reset pin low also ends any frame in progress
  spi_link u_link (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .sclk_i      (sclk_s),
    .cs_n_i      (cs_n_s | pin_reset),
    .di_i        (di_s),
    .stall_i     (hold_on),
    .tx_byte_i   (tx_byte),
    .rx_byte_o   (rx_byte),
    .rx_valid_o  (rx_valid),
    .frame_end_o (frame_end),
    .aligned_o   (aligned),
    .do_o        (io1_do_o)
  );

  assign busy    = (st.kind != OP_IDLE);
  assign exec    = frame_end & aligned & st.cmd_valid;
  assign reading = st.cmd_valid & ((st.cmd == CMD_READ_SR1) |
                   (st.cmd == CMD_READ_SR2) | (st.cmd == CMD_READ_SR3));

  // Read image, re-sampled at each byte so busy can be polled
  always_comb begin
    if (st.cmd == CMD_READ_SR2) begin
      tx_byte = sr2_image(st.vol, st.lock, st.paused); // R12
    end else if (st.cmd == CMD_READ_SR3) begin
      tx_byte = sr3_image(st.vol); // R21
    end else begin
      tx_byte = sr1_image(st.vol, st.write_latch_flag, busy); // R7
    end
  end

  // Write command decode; the third register is never guarded
  always_comb begin
    wr_cmd = 1'b1;
    wr_sel = SEL_SR1;
    if (st.cmd == CMD_WRITE_SR2) begin
      wr_sel = SEL_SR2;
    end else if (st.cmd == CMD_WRITE_SR3) begin
      wr_sel = SEL_SR3;
    end else if (st.cmd != CMD_WRITE_SR1) begin
      wr_cmd = 1'b0;
    end
  end

  assign wr_two     = (wr_sel == SEL_SR1) & (st.nbytes == 2'h2);
  assign wr_blocked = wp_lock & (wr_sel != SEL_SR3); // R20

  always_comb begin
    next_st    = st;
    grant      = 1'b0;
    soft_reset = 1'b0;
    // Byte capture: command first, then up to two data bytes
    if (frame_end) begin
      next_st.cmd_valid = 1'b0;
      next_st.nbytes    = 2'h0;
    end
    if (rx_valid) begin
      if (!st.cmd_valid) begin
        next_st.cmd       = rx_byte;
        next_st.cmd_valid = 1'b1;
      end else if (st.nbytes == 2'h0) begin
        next_st.wdata[15:8] = rx_byte;
        next_st.nbytes      = 2'h1;
      end else if (st.nbytes == 2'h1) begin
        next_st.wdata[7:0] = rx_byte;
        next_st.nbytes     = 2'h2;
      end
    end
    // Progress of the embedded operation
    unique case (st.kind)
      OP_IDLE: begin
      end
      OP_STATUS: begin
        if (st.timer == '0) begin
          next_st.nv   = apply_write(st.nv, st.pend_sel, st.pend_two,
                                     st.pend_data);
          next_st.vol  = apply_write(st.vol, st.pend_sel, st.pend_two,
                                     st.pend_data);
          next_st.lock = lock_merge(st.lock, st.pend_sel, st.pend_two,
                                    st.pend_data); // R13
          next_st.write_latch_flag  = 1'b0; // R5
          next_st.kind = OP_IDLE; // R8
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      OP_ARRAY: begin
        if (array_op_done_i) begin
          next_st.kind = OP_IDLE; // R8
        end
      end
      OP_RESET: begin
        if (st.timer == '0) begin
          next_st.kind = OP_IDLE;
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
    endcase
    // Program or erase start needs the latch and an idle device
    if (array_op_req_i && st.write_latch_flag && !busy && !st.paused) begin
      grant        = 1'b1; // R6
      next_st.kind = OP_ARRAY;
      next_st.write_latch_flag  = 1'b0; // R5
    end
    // Commands act at a byte-aligned frame end; ignored in reset
    if (exec && st.kind != OP_RESET) begin
      next_st.armed = 1'b0;
      if (busy) begin
        if (st.cmd == CMD_SUSPEND && st.kind == OP_ARRAY) begin
          next_st.paused = 1'b1; // R12
          next_st.kind   = OP_IDLE;
        end
      end else if (wr_cmd) begin
        if (!wr_blocked && st.nbytes != 2'h0) begin // R10
          if (st.vwe) begin
            next_st.vol = apply_write(st.vol, wr_sel, wr_two,
                                      st.wdata); // R19
            next_st.vwe = 1'b0;
          end else if (st.write_latch_flag) begin
            next_st.kind      = OP_STATUS; // R6
            next_st.timer     = TIMER_W'(TW_CYCLES - 1);
            next_st.pend_sel  = wr_sel;
            next_st.pend_two  = wr_two;
            next_st.pend_data = st.wdata;
          end
        end
      end else if (st.cmd == CMD_WRITE_EN) begin
        next_st.write_latch_flag = 1'b1; // R5
        next_st.vwe = 1'b0;
      end else if (st.cmd == CMD_VOL_WRITE_EN) begin
        next_st.vwe = 1'b1; // R19
      end else if (st.cmd == CMD_WRITE_DIS) begin
        next_st.write_latch_flag = 1'b0; // R5
        next_st.vwe = 1'b0;
      end else if (st.cmd == CMD_RESUME && st.paused) begin
        next_st.paused = 1'b0;
        next_st.kind   = OP_ARRAY;
      end else if (st.cmd == CMD_RESET_EN) begin
        next_st.armed = 1'b1;
      end else if (st.cmd == CMD_RESET && st.armed) begin
        soft_reset = 1'b1;
      end
    end
    // Either reset aborts work and reloads the working copies
    if (soft_reset || pin_reset) begin
      next_st.vol       = st.nv; // R18
      next_st.write_latch_flag       = 1'b0;
      next_st.vwe       = 1'b0;
      next_st.paused    = 1'b0;
      next_st.armed     = 1'b0;
      next_st.cmd_valid = 1'b0;
      next_st.kind      = OP_RESET;
      next_st.timer     = TIMER_W'(RST_CYCLES - 1);
    end
  end

  // Power-up state equals factory defaults in both copies
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= '0; // R4
    end else begin
      st <= next_st;
    end
  end

  // Protection fields for the array controller
  always_comb begin
    protection_o.granularity = st.vol.granularity; // R2
    protection_o.range       = st.vol.range; // R3
    protection_o.top_bottom  = st.vol.top_bottom; // R9
    protection_o.invert      = st.vol.invert; // R11
  end

  // Data line released while paused by hold
  assign io1_do_oe_n_o    = ~(reading & ~cs_n_s & ~hold_on);
  assign array_grant_o    = grant;
  assign device_reset_o   = soft_reset | pin_reset;
  assign security_lock_o  = st.lock;
  assign quad_io_enable_o = st.vol.quad;
  assign hold_active_o    = hold_on;
  assign drive_strength_o = st.vol.drive; // R16
  assign high_freq_mode_o = st.vol.high_freq_mode; // R17
  assign write_latch_o    = st.write_latch_flag;
  assign busy_o           = busy;
  assign paused_o         = st.paused;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  property p_wel_set;
    exec && !busy && !pin_reset && st.cmd == CMD_WRITE_EN |=> st.write_latch_flag;
  endproperty
  a_wel_set: assert property (p_wel_set) // R5
    else $error("write latch not set by write enable");

  property p_wel_clear;
    exec && !busy && st.cmd == CMD_WRITE_DIS |=> !st.write_latch_flag;
  endproperty
  a_wel_clear: assert property (p_wel_clear) // R5
    else $error("write latch not cleared by write disable");

  property p_start_needs_wel;
    $rose(busy) && st.kind != OP_RESET && !$past(st.paused)
      |-> $past(st.write_latch_flag);
  endproperty
  a_start_needs_wel: assert property (p_start_needs_wel) // R6
    else $error("operation started without write latch");

  property p_busy_ignores;
    exec && st.kind == OP_STATUS && st.timer != '0 && !pin_reset
      |=> st.write_latch_flag == $past(st.write_latch_flag) && st.vwe == $past(st.vwe);
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) // R7
    else $error("command acted on while busy");

  property p_status_write_ends;
    $rose(st.kind == OP_STATUS) |-> ##[1:TW_BOUND] st.kind != OP_STATUS;
  endproperty
  a_status_write_ends: assert property (p_status_write_ends) // R8
    else $error("status write busy did not end in time");

  property p_guard_rejects;
    exec && !busy && wr_cmd && wr_blocked && !pin_reset
      |=> st.vol == $past(st.vol) && st.kind != OP_STATUS;
  endproperty
  a_guard_rejects: assert property (p_guard_rejects) // R20
    else $error("guarded write was not rejected");

  property p_volatile_only;
    exec && !busy && wr_cmd && st.vwe
      |=> st.lock == $past(st.lock) && st.nv == $past(st.nv);
  endproperty
  a_volatile_only: assert property (p_volatile_only) // R19
    else $error("volatile write touched non-volatile state");

  property p_paused_not_running;
    st.paused |-> st.kind != OP_ARRAY;
  endproperty
  a_paused_not_running: assert property (p_paused_not_running) // R12
    else $error("array operation running while paused");

  property p_quad_disables_pins;
    st.vol.quad |-> !hold_on && !pin_reset && !wp_lock;
  endproperty
  a_quad_disables_pins: assert property (p_quad_disables_pins) // R14
    else $error("pin function active in quad mode");

  property p_reserved_zero;
    reading && st.cmd == CMD_READ_SR3 |-> tx_byte[3:0] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R21
    else $error("reserved bits read nonzero");

  property p_reset_reload;
    pin_reset |=> st.vol == $past(st.nv) && !st.write_latch_flag && busy;
  endproperty
  a_reset_reload: assert property (p_reset_reload) // R18
    else $error("reset did not reload volatile copies");

endmodule

// File: flash_status_pkg.sv
package flash_status_pkg;

  // Timing, kept in nanoseconds and converted to system clock cycles
  localparam int SYS_CLK_HZ          = 50_000_000;
  localparam int STATUS_WRITE_NS     = 10_000;
  localparam int SOFT_RESET_NS       = 10_000;
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SOFT_RESET_CYCLES   =
    (SOFT_RESET_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TIMER_W             = 16;

  // Serial command codes
  localparam logic [7:0] CMD_WRITE_EN     = 8'h06;
  localparam logic [7:0] CMD_VOL_WRITE_EN = 8'h50;
  localparam logic [7:0] CMD_WRITE_SR1    = 8'h01;
  localparam logic [7:0] CMD_WRITE_SR2    = 8'h31;
  localparam logic [7:0] CMD_SUSPEND      = 8'h75;
  localparam logic [7:0] CMD_RESUME       = 8'h7A;
  localparam logic [7:0] CMD_RESET_EN     = 8'h66;
  localparam logic [7:0] CMD_RESET        = 8'h99;

  // Field positions inside the three status images
  localparam int SR1_GUARD_BIT   = 7;
  localparam int SR1_GRAN_BIT    = 6;
  localparam int SR1_TB_BIT      = 5;
  localparam int SR1_RANGE_HI    = 4;
  localparam int SR1_RANGE_LO    = 2;
  localparam int SR2_INVERT_BIT  = 6;
  localparam int SR2_LOCK_HI     = 5;
  localparam int SR2_LOCK_LO     = 3;
  localparam int SR2_QUAD_BIT    = 1;
  localparam int SR3_PIN_SEL_BIT = 7;
  localparam int SR3_DRIVE_HI    = 6;
  localparam int SR3_DRIVE_LO    = 5;
  localparam int SR3_HFM_BIT     = 4;

  // Register selectors for a pending write
  localparam logic [1:0] SEL_SR1 = 2'h1;
  localparam logic [1:0] SEL_SR2 = 2'h2;
  localparam logic [1:0] SEL_SR3 = 2'h3;

  typedef struct packed {
    logic       guard;
    logic       granularity;
    logic       top_bottom;
    logic [2:0] range;
    logic       invert;
    logic       quad;
    logic       pin_sel;
    logic [1:0] drive;
    logic       high_freq_mode;
  } cfg_type;

  typedef struct packed {
    logic       invert;
    logic       granularity;
    logic       top_bottom;
    logic [2:0] range;
  } protection_type;

  typedef enum logic [1:0] {OP_IDLE, OP_STATUS, OP_ARRAY, OP_RESET}
    op_kind_type;

  typedef struct packed {
    logic       sclk_d;
    logic       cs_d;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic       dout;
    logic       rx_valid;
    logic       frame_end;
    logic       aligned;
  } link_state_type;

  localparam cfg_type CFG_RESET = '0;

  function automatic logic [7:0] sr1_image(cfg_type c, logic write_latch_flag,
                                           logic busy);
    return {c.guard, c.granularity, c.top_bottom, c.range, write_latch_flag, busy};
  endfunction

  function automatic logic [7:0] sr2_image(cfg_type c, logic [2:0] lock,
                                           logic paused);
    return {paused, c.invert, lock, 1'b0, c.quad, 1'b0};
  endfunction

  function automatic logic [7:0] sr3_image(cfg_type c);
    return {c.pin_sel, c.drive, c.high_freq_mode, 4'h0};
  endfunction

  // Reserved positions are never copied, so writes to them vanish
  function automatic cfg_type cfg_merge(cfg_type c, logic [1:0] sel,
                                        logic [7:0] d);
    cfg_type r;
    r = c;
    if (sel == SEL_SR1) begin
      r.guard       = d[SR1_GUARD_BIT];
      r.granularity = d[SR1_GRAN_BIT];
      r.top_bottom  = d[SR1_TB_BIT];
      r.range       = d[SR1_RANGE_HI:SR1_RANGE_LO];
    end else if (sel == SEL_SR2) begin
      r.invert = d[SR2_INVERT_BIT];
      r.quad   = d[SR2_QUAD_BIT];
    end else if (sel == SEL_SR3) begin
      r.pin_sel = d[SR3_PIN_SEL_BIT];
      r.drive   = d[SR3_DRIVE_HI:SR3_DRIVE_LO];
      r.high_freq_mode     = d[SR3_HFM_BIT];
    end
    return r;
  endfunction

endpackage

// File: sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st;
  sync_state_type next_st;

  // Meta stage feeds only the second stage
  always_comb begin
    next_st.meta   = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= {RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule

// File: spi_link.sv
`timescale 1ns/1ps
module spi_link
  import flash_status_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       di_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] tx_byte_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            frame_end_o,
  output logic            aligned_o,
  output logic            do_o
);

  link_state_type st;
  link_state_type next_st;
  logic           rise;
  logic           fall;

  // Select idles high, so leaving reset must not fake a frame end
  localparam link_state_type LINK_RESET = '{cs_d: 1'b1, default: '0};

  // Edges are ignored while paused so the shift state survives
  assign rise = sclk_i & ~st.sclk_d & ~cs_n_i & ~stall_i;
  assign fall = ~sclk_i & st.sclk_d & ~cs_n_i & ~stall_i;

  // Mode 0/3: sample on rising edge, shift out on falling edge
  always_comb begin
    next_st           = st;
    next_st.sclk_d    = sclk_i;
    next_st.cs_d      = cs_n_i;
    next_st.rx_valid  = 1'b0;
    next_st.frame_end = 1'b0;
    if (cs_n_i) begin
      next_st.bitcnt = 3'h0;
      if (!st.cs_d) begin
        next_st.frame_end = 1'b1;
        next_st.aligned   = (st.bitcnt == 3'h0);
      end
    end else begin
      if (rise) begin
        next_st.shift    = {st.shift[6:0], di_i};
        next_st.bitcnt   = st.bitcnt + 3'h1;
        next_st.rx_valid = (st.bitcnt == 3'h7);
      end
      if (fall) begin
        if (st.bitcnt == 3'h0) begin
          next_st.dout = tx_byte_i[7];
          next_st.tx   = {tx_byte_i[6:0], 1'b0};
        end else begin
          next_st.dout = st.tx[7];
          next_st.tx   = {st.tx[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st <= LINK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rx_byte_o   = st.shift;
  assign rx_valid_o  = st.rx_valid;
  assign frame_end_o = st.frame_end;
  assign aligned_o   = st.aligned;
  assign do_o        = st.dout;

endmodule

// File: host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_sys_i,
  input  wire logic do_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      di_o
);
  // Mode 0 idle: clock low, select high
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    di_o   = 1'b0;
  end

  // One frame, MSB first, 8 system clocks per serial bit
  task automatic frame(input logic [23:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n * 8; i++) begin
      @(posedge clk_sys_i);
      cs_n_o <= 1'b0;
      sclk_o <= 1'b0;
      di_o   <= tx[23-i];
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      // Sample late in the high phase; 4 low plus 4 high cycles
      repeat (3) @(posedge clk_sys_i);
      rx = {rx[6:0], do_i};
    end
    @(posedge clk_sys_i);
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    // Released data line must not keep its last level
    di_o   <= ~di_o;
    repeat (6) @(posedge clk_sys_i);
  endtask
endmodule

// File: flash_status_config_regs_tb_top.sv
`timescale 1ns/1ps
module flash_status_config_regs_tb_top;
  import flash_status_pkg::*;
  logic           clk_sys_i, rst_b_i, wp_n, hr_n, req, done;
  logic           sclk, cs_n, di, dout, grant, lq, busy, write_latch_flag, paused;
  protection_type prot;
  logic [1:0]     drv;
  logic [2:0]     lock;
  logic           devrst, high_freq_mode;
  logic [7:0]     rd;
  int             num_errors = 0;
  int             num_checks = 0;

  flash_status_config_regs #(.TW_CYCLES(300), .RST_CYCLES(5))
  flash_status_config_regs_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io0_di_i(di), .io2_wp_n_i(wp_n),
    .io3_hold_reset_n_i(hr_n), .array_op_req_i(req),
    .array_op_done_i(done), .io1_do_o(dout), .io1_do_oe_n_o(),
    .array_grant_o(grant), .device_reset_o(devrst), .protection_o(prot),
    .security_lock_o(lock), .quad_io_enable_o(lq), .hold_active_o(),
    .drive_strength_o(drv), .high_freq_mode_o(high_freq_mode), .write_latch_o(write_latch_flag),
    .busy_o(busy), .paused_o(paused));

  host_model host_model_i (.clk_sys_i(clk_sys_i), .do_i(dout),
    .sclk_o(sclk), .cs_n_o(cs_n), .di_o(di));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Bus helpers: one-byte command, command plus data, register read
  task automatic op(input logic [7:0] c);
    host_model_i.frame({c, 16'h0}, 1, rd);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_model_i.frame({c, d, 8'h0}, 2, rd);
  endtask
  task automatic rdsr(input logic [7:0] c);
    host_model_i.frame({c, 16'h0}, 2, rd);
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && busy !== 1'b0; k++)
      @(posedge clk_sys_i);
    chk({7'h0, busy}, 8'h00);
    if (busy !== 1'b0)
      close_out();
  endtask

  task automatic t_reset();
    rdsr(8'h05);
    chk(rd, 8'h00);
    rdsr(8'h35);
    chk(rd, 8'h00);
    rdsr(8'h15);
    chk(rd, 8'h00);
  endtask

  task automatic t_nv();
    op(CMD_WRITE_EN);
    rdsr(8'h05);
    chk(rd, 8'h02);
    wr(CMD_WRITE_SR1, 8'h7C);
    chk({7'h0, busy}, 8'h01);
    op(8'h04);
    rdsr(8'h05);
    chk(rd, 8'h03);
    wait_idle();
    rdsr(8'h05);
    chk(rd, 8'h7C);
    chk({2'h0, prot}, 8'h1F);
    op(CMD_WRITE_EN);
    op(8'h04);
    rdsr(8'h05);
    chk(rd, 8'h7C);
  endtask

  // Guard set with pin low blocks, pin high lets it through
  task automatic t_guard();
    op(CMD_WRITE_EN);
    wr(CMD_WRITE_SR1, 8'hE0);
    wait_idle();
    wp_n <= 1'b0;
    op(CMD_WRITE_EN);
    wr(CMD_WRITE_SR1, 8'h00);
    rdsr(8'h05);
    chk(rd, 8'hE2);
    wp_n <= 1'b1;
    wr(CMD_WRITE_SR1, 8'h00);
    wait_idle();
    rdsr(8'h05);
    chk(rd, 8'h00);
  endtask

  task automatic t_array();
    req <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk({7'h0, grant}, 8'h00);
    @(posedge clk_sys_i);
    req <= 1'b0;
    op(CMD_WRITE_EN);
    req <= 1'b1;
    #1 chk({7'h0, grant}, 8'h01);
    @(posedge clk_sys_i);
    req <= 1'b0;
    #1 chk({6'h0, write_latch_flag, busy}, 8'h01);
    op(CMD_SUSPEND);
    chk({7'h0, paused}, 8'h01);
    op(CMD_RESUME);
    chk({6'h0, paused, busy}, 8'h01);
    done <= 1'b1;
    @(posedge clk_sys_i);
    done <= 1'b0;
    #1 chk({7'h0, busy}, 8'h00);
  endtask

  task automatic t_vol();
    op(CMD_WRITE_EN);
    wr(CMD_WRITE_SR2, 8'h08);
    wait_idle();
    chk({5'h0, lock}, 8'h01);
    op(CMD_VOL_WRITE_EN);
    wr(CMD_WRITE_SR2, 8'h7E);
    chk({7'h0, busy}, 8'h00);
    chk({5'h0, lock}, 8'h01);
    rdsr(8'h35);
    chk(rd, 8'h4A);
    chk({7'h0, lq}, 8'h01);
  endtask

  // Reserved third-register bits must drop written ones
  task automatic t_sr3();
    op(CMD_WRITE_EN);
    wr(8'h11, 8'hFF);
    wait_idle();
    rdsr(8'h15);
    chk(rd, 8'hF0);
    chk({6'h0, drv}, 8'h03);
    chk({7'h0, high_freq_mode}, 8'h01);
  endtask

  // Soft reset then reset pin: working copies come back from storage
  task automatic t_rst();
    op(CMD_RESET_EN);
    op(CMD_RESET);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    rdsr(8'h35);
    chk(rd, 8'h08);
    hr_n <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk({6'h0, devrst, busy}, 8'h03);
    hr_n <= 1'b1;
    wait_idle();
    rdsr(8'h15);
    chk(rd, 8'hF0);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    rst_b_i = 1'b0;
    wp_n    = 1'b1;
    hr_n    = 1'b1;
    req     = 1'b0;
    done    = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset();
    t_nv();
    t_guard();
    t_array();
    t_vol();
    t_sr3();
    t_rst();
    close_out();
  end
endmodule
